// [core/frc_divider.sv]
`timescale 1ns/1ps
module frc_divider
  import frc_pkg::*;
#(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  output logic busy,
  output logic done,
  output logic [W-1:0] quot
);

  localparam int CW = $clog2(W) + 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(1);

  logic [W:0] rem_r;
  logic [W-1:0] quo_r;
  logic [W-1:0] den_r;
  logic [CW-1:0] cnt_r;
  logic [W:0] trial;

  // A zero divisor yields all ones, which the ramp treats as a jump.
  assign trial = {rem_r[W-1:0], quo_r[W-1]};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rem_r <= '0;
      quo_r <= '0;
      den_r <= '0;
      cnt_r <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        rem_r <= '0;
        quo_r <= num;
        den_r <= den;
        cnt_r <= CW'(W);
        busy <= 1'b1;
      end else if (busy) begin
        if (trial >= {1'b0, den_r}) begin
          rem_r <= trial - {1'b0, den_r};
          quo_r <= {quo_r[W-2:0], 1'b1};
        end else begin
          rem_r <= trial;
          quo_r <= {quo_r[W-2:0], 1'b0};
        end
        cnt_r <= cnt_r - CW'(1);
        if (cnt_r == CNT_LAST) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  assign quot = quo_r;

endmodule

// [core/frc_pkg.sv]
package frc_pkg;

  // ----------------------------------------------------------------
  // Scaling and limits
  // ----------------------------------------------------------------
  // Frequencies are in 0.01 Hz, voltages in 0.1 V, ramp times in 0.01 s
  // (unit select 0) or 0.1 s (unit select 1).
  localparam int FREQ_W = 16;
  localparam int FRAC_W = 16;
  localparam int ACC_W = FREQ_W + FRAC_W;
  localparam int TICKS_W = 24;
  localparam logic [15:0] FREQ_LIMIT = 16'h9C40;
  localparam logic [15:0] TIME_LIMIT = 16'hEA60;
  localparam logic [15:0] VOLT_LIMIT_230 = 16'h0960;
  localparam logic [15:0] VOLT_LIMIT_460 = 16'h12C0;
  localparam logic [15:0] ZERO_16 = 16'h0000;
  localparam logic [FRAC_W-1:0] FRAC_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int CTRL_TICK_NS = 1000000;
  localparam int CTRL_TICK_CYCLES = CTRL_TICK_NS / CLK_PERIOD_NS;
  localparam int TIME_LSB0_NS = 10000000;
  localparam int TIME_LSB1_NS = 100000000;
  localparam logic [7:0] TICKS_PER_LSB0 = 8'(TIME_LSB0_NS / CTRL_TICK_NS);
  localparam logic [7:0] TICKS_PER_LSB1 = 8'(TIME_LSB1_NS / CTRL_TICK_NS);
  // Ramp time used by the automatic modes, in 0.01 s.
  localparam logic [15:0] AUTO_RAMP_TIME = 16'h0064;

  // ----------------------------------------------------------------
  // Automatic ramp mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] AUTO_ACC_ONLY = 3'h1;
  localparam logic [2:0] AUTO_DEC_ONLY = 3'h2;
  localparam logic [2:0] AUTO_BOTH = 3'h3;

  // ----------------------------------------------------------------
  // Reset values of the loaded settings
  // ----------------------------------------------------------------
  localparam logic [15:0] DEF_MAX_FREQ = 16'h1770;
  localparam logic [15:0] DEF_MID1_FREQ = 16'h012C;
  localparam logic [15:0] DEF_MID2_FREQ = 16'h0096;
  localparam logic [15:0] DEF_MIN_FREQ = 16'h0032;
  localparam logic [15:0] DEF_MAX_VOLT = 16'h0898;
  localparam logic [15:0] DEF_MID1_VOLT = 16'h006E;
  localparam logic [15:0] DEF_MID2_VOLT = 16'h0032;
  localparam logic [15:0] DEF_MIN_VOLT = 16'h000A;
  localparam logic [15:0] DEF_STARTUP_FREQ = 16'h0032;
  localparam logic [15:0] DEF_CEILING = 16'h9C40;
  localparam logic [15:0] DEF_FLOOR = 16'h0000;
  localparam logic [15:0] DEF_INCHING_FREQ = 16'h0258;
  localparam logic [15:0] DEF_RAMP_TIME = 16'h03E8;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] max_freq;
    logic [15:0] mid1_freq;
    logic [15:0] mid2_freq;
    logic [15:0] minimum_output_frequency_setting;
    logic [15:0] max_volt;
    logic [15:0] mid1_volt;
    logic [15:0] mid2_volt;
    logic [15:0] min_volt;
  } frc_vf_curve_t;

  typedef struct packed {
    logic [15:0] startup_frequency_parameter;
    logic [15:0] output_frequency_ceiling;
    logic [15:0] output_frequency_floor_setting;
    logic [15:0] inching_frequency_setting;
  } frc_limits_t;

  typedef struct packed {
    logic [3:0][15:0] accel;
    logic [3:0][15:0] decel;
    logic [15:0] inch_accel;
    logic [15:0] inch_decel;
  } frc_times_t;

  typedef enum logic [2:0] {
    ST_READY,
    ST_RUN,
    ST_STOP,
    ST_INCH,
    ST_INCH_STOP
  } frc_state_t;

  function automatic logic [15:0] frc_clamp(input logic [15:0] v, input logic [15:0] lim);
    frc_clamp = (v > lim) ? lim : v;
  endfunction

endpackage

// [core/frc_ramp_top.sv]
`timescale 1ns/1ps
module frc_ramp_top
  import frc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = CTRL_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cfg_load,
  input frc_vf_curve_t curve_in,
  input frc_limits_t limits_in,
  input frc_times_t times_in,
  input wire logic voltage_class_460,
  input wire logic ramp_time_unit_select,
  input wire logic [2:0] automatic_ramp_mode_select,
  input wire logic [1:0] ramp_pair_select,
  input wire logic run_cmd,
  input wire logic inching_command,
  input wire logic [15:0] freq_cmd,
  input wire logic slip_comp_active,
  input wire logic [15:0] slip_comp_freq,
  input wire logic ramp_extend,
  output logic [15:0] out_freq_r,
  output logic [15:0] out_volt_r,
  output logic output_active_r,
  output logic ready_r,
  output logic inching_active_r,
  output logic accel_r,
  output logic decel_r,
  output logic at_target_r
);

  // ----------------------------------------------------------------
  // Loaded settings
  // ----------------------------------------------------------------
  frc_vf_curve_t curve_r;
  frc_limits_t lim_r;
  frc_times_t times_r;
  logic [15:0] vlim;

  assign vlim = voltage_class_460 ? VOLT_LIMIT_460 : VOLT_LIMIT_230;

  // Settings are sampled only on cfg_load so a half-written set never steers the ramp.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      curve_r <= '{DEF_MAX_FREQ, DEF_MID1_FREQ, DEF_MID2_FREQ, DEF_MIN_FREQ,
                   DEF_MAX_VOLT, DEF_MID1_VOLT, DEF_MID2_VOLT, DEF_MIN_VOLT};
      lim_r <= '{DEF_STARTUP_FREQ, DEF_CEILING, DEF_FLOOR, DEF_INCHING_FREQ};
    end else if (cfg_load) begin
      curve_r.max_freq <= frc_clamp(curve_in.max_freq, FREQ_LIMIT);
      curve_r.mid1_freq <= frc_clamp(curve_in.mid1_freq, FREQ_LIMIT);
      curve_r.mid2_freq <= frc_clamp(curve_in.mid2_freq, FREQ_LIMIT);
      curve_r.minimum_output_frequency_setting <=
        frc_clamp(curve_in.minimum_output_frequency_setting, FREQ_LIMIT);
      curve_r.max_volt <= frc_clamp(curve_in.max_volt, vlim);
      curve_r.mid1_volt <= frc_clamp(curve_in.mid1_volt, vlim);
      curve_r.mid2_volt <= frc_clamp(curve_in.mid2_volt, vlim);
      curve_r.min_volt <= frc_clamp(curve_in.min_volt, vlim);
      lim_r.startup_frequency_parameter <=
        frc_clamp(limits_in.startup_frequency_parameter, FREQ_LIMIT);
      lim_r.output_frequency_ceiling <=
        frc_clamp(limits_in.output_frequency_ceiling, FREQ_LIMIT);
      lim_r.output_frequency_floor_setting <=
        frc_clamp(limits_in.output_frequency_floor_setting, FREQ_LIMIT);
      lim_r.inching_frequency_setting <=
        frc_clamp(limits_in.inching_frequency_setting, FREQ_LIMIT);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) begin
        times_r.accel[i] <= DEF_RAMP_TIME;
        times_r.decel[i] <= DEF_RAMP_TIME;
      end
      times_r.inch_accel <= DEF_RAMP_TIME;
      times_r.inch_decel <= DEF_RAMP_TIME;
    end else if (cfg_load) begin
      for (int i = 0; i < 4; i++) begin
        times_r.accel[i] <= frc_clamp(times_in.accel[i], TIME_LIMIT);
        times_r.decel[i] <= frc_clamp(times_in.decel[i], TIME_LIMIT);
      end
      times_r.inch_accel <= frc_clamp(times_in.inch_accel, TIME_LIMIT);
      times_r.inch_decel <= frc_clamp(times_in.inch_decel, TIME_LIMIT);
    end
  end

  // ----------------------------------------------------------------
  // Control tick
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_r;
  logic tick_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (tick_cnt_r >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Target frequency
  // ----------------------------------------------------------------
  frc_state_t state_r;
  frc_state_t state_nxt;
  logic [ACC_W-1:0] ramp_r;
  logic [15:0] ramp_freq;
  logic [15:0] target_r;
  logic [15:0] target_nxt;
  logic [15:0] fmin;
  logic [15:0] cmd_clamp;
  logic [15:0] run_target;
  logic [15:0] start_freq;
  logic load_en;
  logic [15:0] load_val;

  assign ramp_freq = ramp_r[ACC_W-1:FRAC_W];
  assign fmin = curve_r.minimum_output_frequency_setting;
  assign cmd_clamp = frc_clamp(freq_cmd, lim_r.output_frequency_ceiling);

  always_comb begin
    if (cmd_clamp < fmin) begin
      run_target = ZERO_16;
    end else if (cmd_clamp < lim_r.output_frequency_floor_setting) begin
      // The floor is clamped to the ceiling in case it is configured above it.
      run_target = frc_clamp(lim_r.output_frequency_floor_setting,
                             lim_r.output_frequency_ceiling);
    end else begin
      run_target = cmd_clamp;
    end
  end

  // Output starts at the start-up frequency, or at the command when that is lower (at the minimum frequency if start-up is not above it),
  // then ramps to the floor if needed; the floor is never forced onto the jump.
  always_comb begin
    if (lim_r.startup_frequency_parameter > fmin) begin
      start_freq = (cmd_clamp < lim_r.startup_frequency_parameter) ?
                   cmd_clamp : lim_r.startup_frequency_parameter;
    end else begin
      start_freq = fmin;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    load_en = 1'b0;
    load_val = ZERO_16;
    case (state_r)
      ST_READY: begin
        if (inching_command) begin
          state_nxt = ST_INCH;
          load_en = 1'b1;
        end else if (run_cmd && (run_target != ZERO_16)) begin
          state_nxt = ST_RUN;
          load_en = 1'b1;
          load_val = start_freq;
        end
      end
      ST_RUN: begin
        // Inching is not looked at here.
        if (!run_cmd || (run_target == ZERO_16)) begin
          state_nxt = ST_STOP;
        end
      end
      ST_STOP: begin
        if (run_cmd && (run_target != ZERO_16)) begin
          state_nxt = ST_RUN;
        end else if (ramp_freq <= fmin) begin
          state_nxt = ST_READY;
          load_en = 1'b1;
        end
      end
      ST_INCH: begin
        if (!inching_command) begin
          state_nxt = ST_INCH_STOP;
        end
      end
      ST_INCH_STOP: begin
        // Run commands stay ignored until the inching ramp is back at zero.
        if (inching_command) begin
          state_nxt = ST_INCH;
        end else if (ramp_r == '0) begin
          state_nxt = ST_READY;
        end
      end
      default: begin
        state_nxt = ST_READY;
        load_en = 1'b1;
      end
    endcase
  end

  always_comb begin
    case (state_nxt)
      ST_RUN: target_nxt = run_target;
      ST_INCH: target_nxt = lim_r.inching_frequency_setting;
      default: target_nxt = ZERO_16;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_READY;
      target_r <= ZERO_16;
    end else begin
      state_r <= state_nxt;
      target_r <= target_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Ramp step
  // ----------------------------------------------------------------
  logic inching;
  logic going_up;
  logic auto_time;
  logic [15:0] time_sel;
  logic [7:0] lsb_ticks;
  logic [15:0] scale_freq;
  logic [TICKS_W-1:0] ticks;
  logic step_start_r;
  logic step_busy;
  logic step_done;
  logic [ACC_W-1:0] step_quot;
  logic [ACC_W-1:0] step_r;
  logic [ACC_W-1:0] step_num;
  logic [ACC_W-1:0] step_den;
  logic [2*ACC_W-1:0] step_key_r;
  logic [2*ACC_W-1:0] step_used_r;
  logic step_fresh;

  assign inching = (state_r == ST_INCH) || (state_r == ST_INCH_STOP);
  assign going_up = ramp_freq < target_r;
  assign step_num = {scale_freq, FRAC_ZERO};
  assign step_den = ACC_W'(ticks);
  // A step left over from the previous selection would be applied at the wrong slope.
  assign step_fresh = step_used_r == {step_num, step_den};

  always_comb begin
    auto_time = 1'b0;
    if (!inching) begin
      if (going_up) begin
        auto_time = (automatic_ramp_mode_select == AUTO_ACC_ONLY) ||
                    (automatic_ramp_mode_select == AUTO_BOTH);
      end else begin
        auto_time = (automatic_ramp_mode_select == AUTO_DEC_ONLY) ||
                    (automatic_ramp_mode_select == AUTO_BOTH);
      end
    end
    if (inching) begin
      time_sel = going_up ? times_r.inch_accel : times_r.inch_decel;
      scale_freq = lim_r.inching_frequency_setting;
    end else begin
      // Pair select zero is the first pair.
      time_sel = going_up ? times_r.accel[ramp_pair_select] :
                            times_r.decel[ramp_pair_select];
      scale_freq = curve_r.max_freq;
    end
    lsb_ticks = ramp_time_unit_select ? TICKS_PER_LSB1 : TICKS_PER_LSB0;
    if (auto_time) begin
      time_sel = AUTO_RAMP_TIME;
      lsb_ticks = TICKS_PER_LSB0;
    end
    ticks = TICKS_W'(time_sel) * TICKS_W'(lsb_ticks);
  end

  // The step is recomputed continuously; ticks are skipped until a division of
  // the present selection has finished, which stretches the ramp slightly.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      step_start_r <= 1'b0;
      step_r <= '0;
      step_key_r <= '0;
      step_used_r <= '0;
    end else begin
      step_start_r <= !step_busy && !step_start_r;
      if (step_start_r && !step_busy) begin
        step_key_r <= {step_num, step_den};
      end
      if (step_done) begin
        step_r <= step_quot;
        step_used_r <= step_key_r;
      end
    end
  end

  frc_divider #(.W(ACC_W)) u_step_div (
    .clk(clk),
    .rstn(rstn),
    .start(step_start_r),
    .num(step_num),
    .den(step_den),
    .busy(step_busy),
    .done(step_done),
    .quot(step_quot)
  );

  // ----------------------------------------------------------------
  // Ramp accumulator
  // ----------------------------------------------------------------
  logic [ACC_W-1:0] target_fx;
  logic [ACC_W:0] sum_up;

  assign target_fx = {target_r, FRAC_ZERO};
  assign sum_up = {1'b0, ramp_r} + {1'b0, step_r};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ramp_r <= '0;
    end else if (load_en) begin
      ramp_r <= {load_val, FRAC_ZERO};
    end else if (tick_r && !ramp_extend && step_fresh) begin
      if (ramp_r < target_fx) begin
        ramp_r <= (sum_up >= {1'b0, target_fx}) ? target_fx : sum_up[ACC_W-1:0];
      end else if (ramp_r > target_fx) begin
        ramp_r <= ((ramp_r - target_fx) <= step_r) ? target_fx : ramp_r - step_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Volts per hertz
  // ----------------------------------------------------------------
  logic [15:0] vf_base;
  logic [31:0] vf_num;
  logic [31:0] vf_den;
  logic vf_neg;
  logic vf_flat;
  logic vdiv_start_r;
  logic vdiv_busy;
  logic vdiv_done;
  logic [31:0] vdiv_quot;
  logic [15:0] volt_r;

  frc_vf_curve u_vf_curve (
    .clk(clk),
    .rstn(rstn),
    .freq(ramp_freq),
    .curve(curve_r),
    .base_r(vf_base),
    .num_r(vf_num),
    .den_r(vf_den),
    .neg_r(vf_neg),
    .flat_r(vf_flat)
  );

  frc_divider #(.W(32)) u_volt_div (
    .clk(clk),
    .rstn(rstn),
    .start(vdiv_start_r),
    .num(vf_num),
    .den(vf_den),
    .busy(vdiv_busy),
    .done(vdiv_done),
    .quot(vdiv_quot)
  );

  // Base and direction are taken at completion; the ramp moves at most one step
  // per tick, so they still belong to the same segment as the quotient.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vdiv_start_r <= 1'b0;
      volt_r <= ZERO_16;
    end else begin
      vdiv_start_r <= !vdiv_busy && !vdiv_start_r;
      if (vdiv_done) begin
        if (vf_flat) begin
          volt_r <= vf_base;
        end else if (vf_neg) begin
          volt_r <= vf_base - vdiv_quot[15:0];
        end else begin
          volt_r <= vf_base + vdiv_quot[15:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic active;
  logic [16:0] freq_sum;

  assign active = state_r != ST_READY;
  // Slip compensation rides on top of the ramp and may exceed the command.
  assign freq_sum = {1'b0, ramp_freq} + {1'b0, (slip_comp_active ? slip_comp_freq : ZERO_16)};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_freq_r <= ZERO_16;
      out_volt_r <= ZERO_16;
      output_active_r <= 1'b0;
      ready_r <= 1'b1;
      inching_active_r <= 1'b0;
      accel_r <= 1'b0;
      decel_r <= 1'b0;
      at_target_r <= 1'b0;
    end else begin
      if (!active) begin
        out_freq_r <= ZERO_16;
      end else if (freq_sum > {1'b0, FREQ_LIMIT}) begin
        out_freq_r <= FREQ_LIMIT;
      end else begin
        out_freq_r <= freq_sum[15:0];
      end
      out_volt_r <= active ? volt_r : ZERO_16;
      output_active_r <= active;
      ready_r <= !active;
      inching_active_r <= inching;
      accel_r <= active && (ramp_r < target_fx);
      decel_r <= active && (ramp_r > target_fx);
      at_target_r <= active && (ramp_r == target_fx);
    end
  end

endmodule

// [core/frc_vf_curve.sv]
`timescale 1ns/1ps
module frc_vf_curve
  import frc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] freq,
  input frc_vf_curve_t curve,
  output logic [15:0] base_r,
  output logic [31:0] num_r,
  output logic [31:0] den_r,
  output logic neg_r,
  output logic flat_r
);

  logic [15:0] f_lo, f_hi, v_lo, v_hi, dv;
  logic flat;

  // ----------------------------------------------------------------
  // Segment selection
  // ----------------------------------------------------------------
  always_comb begin
    f_lo = curve.minimum_output_frequency_setting;
    f_hi = curve.mid2_freq;
    v_lo = curve.min_volt;
    v_hi = curve.mid2_volt;
    flat = 1'b0;
    if (freq <= curve.minimum_output_frequency_setting) begin
      flat = 1'b1;
    end else if (freq >= curve.max_freq) begin
      v_lo = curve.max_volt;
      flat = 1'b1;
    end else if (freq >= curve.mid1_freq) begin
      f_lo = curve.mid1_freq;
      f_hi = curve.max_freq;
      v_lo = curve.mid1_volt;
      v_hi = curve.max_volt;
    end else if (freq >= curve.mid2_freq) begin
      f_lo = curve.mid2_freq;
      f_hi = curve.mid1_freq;
      v_lo = curve.mid2_volt;
      v_hi = curve.mid1_volt;
    end
    // A collapsed segment has no slope; hold its lower voltage.
    if (f_hi <= f_lo) begin
      flat = 1'b1;
    end
    dv = (v_hi >= v_lo) ? (v_hi - v_lo) : (v_lo - v_hi);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      base_r <= '0;
      num_r <= '0;
      den_r <= '0;
      neg_r <= 1'b0;
      flat_r <= 1'b1;
    end else begin
      base_r <= v_lo;
      num_r <= 32'(freq - f_lo) * 32'(dv);
      den_r <= {16'h0000, 16'(f_hi - f_lo)};
      neg_r <= v_hi < v_lo;
      flat_r <= flat;
    end
  end

endmodule

// [verif/frc_op_src.sv]
`timescale 1ns/1ps
module frc_op_src
  import frc_pkg::*;
(
  input wire logic clk,
  input wire logic [17:0] req,
  output logic run_cmd,
  output logic inching_command,
  output logic [15:0] freq_cmd,
  output frc_limits_t limits_in
);
  // Ceiling 100 Hz stays above floor 10 Hz, so the limit pair is always legal.
  // Start-up frequency 2.00 Hz sits above the minimum frequency.
  assign limits_in = {16'h00C8, 16'h2710, 16'h03E8, DEF_INCHING_FREQ};
  initial {run_cmd, inching_command, freq_cmd} = 18'h00000;
  always @(negedge clk) {run_cmd, inching_command, freq_cmd} <= req;
endmodule

// [verif/frc_ramp_props.sv]
`timescale 1ns/1ps
module frc_ramp_props
  import frc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic run_cmd,
  input wire logic inching_command,
  input wire logic [15:0] freq_cmd,
  input wire logic slip_comp_active,
  input wire logic [15:0] out_freq_r,
  input wire logic [15:0] out_volt_r,
  input wire logic output_active_r,
  input wire logic ready_r,
  input wire logic inching_active_r,
  input wire logic accel_r,
  input wire logic decel_r,
  input wire logic at_target_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_READY_INV: assert property (ready_r == !output_active_r)
    else $error("ready and active disagree");
  AST_IDLE: assert property (ready_r |-> !(accel_r || decel_r || at_target_r)
    && out_freq_r == 16'h0000 && out_volt_r == 16'h0000) else $error("idle output not zero");
  AST_CAUSE: assert property ($rose(output_active_r)
    |-> $past(run_cmd, 2) || $past(inching_command, 2)) else $error("start without command");
  AST_START_LOW: assert property ($rose(output_active_r) && !inching_active_r
    && !slip_comp_active |-> out_freq_r <= $past(freq_cmd, 2)) else $error("start too high");
  AST_INCH_REFUSED: assert property (output_active_r && !inching_active_r
    |=> !inching_active_r) else $error("inching accepted while running");
  AST_INCH_END: assert property ($fell(inching_active_r) |-> ready_r)
    else $error("inching left for run");
  AST_ONE_FLAG: assert property (output_active_r |-> $onehot({accel_r, decel_r, at_target_r}))
    else $error("ramp flags not exclusive");
  AST_CEIL: assert property (out_freq_r <= FREQ_LIMIT)
    else $error("output above 400 Hz");
  cover property ($rose(inching_active_r));
  cover property ($rose(at_target_r) && !inching_active_r);
  cover property ($fell(output_active_r));
endmodule
bind frc_ramp_top frc_ramp_props u_chk (.clk, .rstn, .run_cmd, .inching_command, .freq_cmd,
  .slip_comp_active, .out_freq_r, .out_volt_r, .output_active_r, .ready_r, .inching_active_r,
  .accel_r, .decel_r, .at_target_r);

// [verif/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import frc_pkg::*;
  logic clk = 1'h0, rstn = 1'h0, cfg_load = 1'h0, run_cmd, inching_command;
  logic [15:0] freq_cmd, out_freq_r, out_volt_r, slip_comp_freq = 16'h0000;
  logic [17:0] req = 18'h00000;
  logic [1:0] ramp_pair_select = 2'h0;
  logic [2:0] automatic_ramp_mode_select = 3'h0;
  logic voltage_class_460 = 1'h0, ramp_time_unit_select = 1'h0;
  logic slip_comp_active = 1'h0, ramp_extend = 1'h0;
  logic output_active_r, ready_r, inching_active_r, accel_r, decel_r, at_target_r;
  frc_vf_curve_t curve_in;
  frc_limits_t limits_in;
  frc_times_t times_in;
  int failures = 0, n_checks = 0, cyc = 0;
  int tc [6] = '{16, 256, 5000, 6000, 65535, 0};
  // One LSB ramp times keep each full-scale ramp to 10 ticks (100 with unit select 1).
  assign times_in = {10{16'h0001}};
  assign curve_in = {DEF_MAX_FREQ, DEF_MID1_FREQ, DEF_MID2_FREQ, DEF_MIN_FREQ,
    DEF_MAX_VOLT, DEF_MID1_VOLT, DEF_MID2_VOLT, DEF_MIN_VOLT};
  always #4 clk = ~clk;
  frc_ramp_top #(.TICK_CYCLES(20)) DUT (.clk, .rstn, .cfg_load, .curve_in, .limits_in,
    .times_in, .voltage_class_460, .ramp_time_unit_select, .automatic_ramp_mode_select,
    .ramp_pair_select, .run_cmd, .inching_command, .freq_cmd, .slip_comp_active,
    .slip_comp_freq, .ramp_extend, .out_freq_r, .out_volt_r, .output_active_r, .ready_r,
    .inching_active_r, .accel_r, .decel_r, .at_target_r);
  frc_op_src u_src (.clk, .req, .run_cmd, .inching_command, .freq_cmd, .limits_in);
  function automatic logic [15:0] tgt(int c);
    tgt = c < 50 ? 16'h0000 : c > 10000 ? 16'h2710 : c < 1000 ? 16'h03E8 : 16'(c);
  endfunction
  task summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(string n, logic [15:0] e, logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task hold(int n);
    repeat (n) @(negedge clk);
  endtask
  task go(logic r, logic i, logic [15:0] c);
    req <= {r, i, c};
    hold(4);
    for (int k = 0; k < 20000 && at_target_r !== 1'h1 && ready_r !== 1'h1; k++) hold(1);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    void'($urandom(12189));
    tc[5] = $urandom % 12288;
    hold(8);
    rstn = 1'h1;
    chk("ready", 16'h0001, 16'(ready_r));
    cfg_load = 1'h1;
    hold(1);
    cfg_load = 1'h0;
    foreach (tc[k]) begin
      ramp_pair_select = 2'($urandom);
      go(1'h1, 1'h0, 16'(tc[k]));
      chk("freq", tgt(tc[k]), out_freq_r);
      hold(100);
      if (tgt(tc[k]) >= 6000) chk("volt", 16'h0898, out_volt_r);
      go(1'h0, 1'h0, 16'(tc[k]));
      chk("stop", 16'h0000, out_freq_r);
      $display("test cmd %0d done", tc[k]);
    end
    req <= {2'h1, 16'h0000};
    hold(44);
    chk("inch_slope", 16'h0001, 16'(out_freq_r < 16'h0258));
    go(1'h0, 1'h1, 16'h0000);
    chk("inch", 16'h0258, out_freq_r);
    go(1'h1, 1'h1, 16'h1388);
    chk("inch_hold", 16'h0258, out_freq_r);
    go(1'h0, 1'h0, 16'h0000);
    go(1'h1, 1'h0, 16'h1388);
    go(1'h1, 1'h1, 16'h1388);
    chk("no_inch", 16'h0000, 16'(inching_active_r));
    go(1'h0, 1'h0, 16'h0000);
    $display("test inching done");
    automatic_ramp_mode_select = 3'h3;
    req <= {2'h2, 16'h07D0};
    hold(60);
    chk("auto", 16'h0001, 16'(out_freq_r < 16'h0100));
    go(1'h1, 1'h0, 16'h07D0);
    chk("auto_freq", 16'h07D0, out_freq_r);
    go(1'h0, 1'h0, 16'h0000);
    $display("test auto done");
    automatic_ramp_mode_select = 3'h0;
    ramp_extend = 1'h1;
    req <= {2'h2, 16'h1388};
    hold(100);
    chk("frozen", 16'h00C8, out_freq_r);
    ramp_extend = 1'h0;
    go(1'h1, 1'h0, 16'h1388);
    slip_comp_freq = 16'h0064;
    slip_comp_active = 1'h1;
    hold(2);
    chk("slip", 16'h13EC, out_freq_r);
    slip_comp_active = 1'h0;
    ramp_time_unit_select = 1'h1;
    req <= {2'h2, 16'h1770};
    hold(140);
    chk("unit", 16'h0001, 16'(out_freq_r < 16'h15E0));
    go(1'h1, 1'h0, 16'h1770);
    chk("unit_freq", 16'h1770, out_freq_r);
    ramp_time_unit_select = 1'h0;
    go(1'h0, 1'h0, 16'h0000);
    chk("unit_stop", 16'h0000, out_freq_r);
    $display("test extend slip unit done");
    summarize();
  end
endmodule
